// >>> inc/msd_pkg.sv
// Package: constants, register map and carrier types for the speed data select monitor
package msd_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] MSD_OFF_CTRL   = 8'h00;
   localparam logic [7:0] MSD_OFF_STATUS = 8'h04;
   localparam logic [7:0] MSD_OFF_IRQ_ST = 8'h08;
   localparam logic [7:0] MSD_OFF_IRQ_MK = 8'h0c;
   localparam logic [7:0] MSD_OFF_ALARM  = 8'h10;
   localparam logic [7:0] MSD_OFF_DSEL   = 8'h14;
   localparam logic [7:0] MSD_OFF_SPEED  = 8'h18;
   localparam logic [7:0] MSD_OFF_ACC    = 8'h1c;
   localparam logic [7:0] MSD_OFF_DEC    = 8'h20;
   localparam logic [7:0] MSD_OFF_RATIO  = 8'h24;
   localparam logic [7:0] MSD_OFF_MONSPD = 8'h28;
   localparam logic [7:0] MSD_OFF_HIST0  = 8'h40;
   // ==========================================================
   // Control register bits
   localparam int MSD_CTRL_HZ60   = 0;
   localparam int MSD_CTRL_DECEL  = 1;
   localparam int MSD_CTRL_INIT   = 2;
   localparam int MSD_CTRL_ARST   = 3;
   localparam int MSD_CTRL_HCLR   = 4;
   localparam int MSD_CTRL_RATIO  = 5;
   // Interrupt bits
   localparam int MSD_IRQ_ALARM   = 0;
   localparam int MSD_IRQ_REFUSE  = 1;
   localparam int MSD_IRQ_RANGE   = 2;
   localparam int MSD_IRQ_SELCHG  = 3;
   // ==========================================================
   // Value limits and defaults (speed r/min, times in 0.1 s)
   localparam logic [15:0] MSD_SPD_MIN     = 16'd300;
   localparam logic [15:0] MSD_SPD_MIN_DEC = 16'd90;
   localparam logic [15:0] MSD_SPD_MAX50   = 16'd1400;
   localparam logic [15:0] MSD_SPD_MAX60   = 16'd1600;
   localparam logic [15:0] MSD_SPD_RST     = 16'd0;
   localparam logic [7:0]  MSD_TIM_MIN     = 8'd2;
   localparam logic [7:0]  MSD_TIM_MIN_DEC = 8'd0;
   localparam logic [7:0]  MSD_TIM_MAX     = 8'd150;
   localparam logic [7:0]  MSD_TIM_RST     = 8'd2;
   localparam logic [7:0]  MSD_TIM_RST_DEC = 8'd0;
   localparam logic [15:0] MSD_RATIO_RST   = 16'd100;  // Ratio in hundredths, 1.00
   localparam int          MSD_HIST_DEPTH  = 9;
   // ==========================================================
   // One operation data set
   typedef struct packed {
      logic [15:0] speed;
      logic [7:0]  acc;
      logic [7:0]  dec;
   } msd_set_t;
   // Wishbone request carrier
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } msd_wb_req_t;
endpackage : msd_pkg

// >>> core/msd_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module msd_sync
   import msd_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         sys_rst_i,
   // Async input and clean output
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } msd_sync_st_t;
   msd_sync_st_t st_reg, st_next;

   // ==========================================================
   // Stage one feeds only stage two; output follows when stages two and three agree
   always_comb begin
      st_next     = st_reg;
      st_next.s1  = async_i;
      st_next.s2  = st_reg.s1;
      st_next.s3  = st_reg.s2;
      for (int i = 0; i < W; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.out[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_o = st_reg.out;
endmodule : msd_sync
`default_nettype wire

// >>> core/msd_core.sv
// Speed data select and panel monitor core with Wishbone register slave
// Function
// - Hold four operation data sets, chosen by the two data select inputs.
// - While motor runs, refuse setting changes and commands, flag an error.
// - Keep history of nine latest alarm codes, clearable by software.
// - Show the raised alarm code on the monitor; allow alarm reset.
// - Light each I/O monitor segment while its signal is on.
// - Alarm output stays on in normal operation, off on alarm.
// - Speed is 0 or 300 up to 1400 (50 Hz) or 1600 (60 Hz).
// - Deceleration control lowers speed minimum to 90 and allows 0.0 s decel.
// - Acceleration and deceleration times 0.2 to 15.0 s, default 0.2 s, except decel 0.0 s after initialize under deceleration control.
// - Initialize command restores all operation data to defaults.
// - Data-mode display suffix digit is the selected set index 0 to 3.
// - Monitor shows the number of the currently selected data set.
// - With a ratio configured, show converted speed instead of shaft speed.
`timescale 1ns/10ps
`default_nettype none
module msd_core
   import msd_pkg::*;
#(
   parameter int NSETS   = 4,
   parameter int NIN     = 6,
   parameter int NOUT    = 2
) (
   // Clock and reset
   input  wire logic            mclk_i,
   input  wire logic            sys_rst_i,
   // Wishbone slave
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic      [31:0]     wb_dat_o,
   output logic                 wb_ack_o,
   // External pins
   input  wire logic            data_select_low_i,
   input  wire logic            data_select_high_i,
   input  wire logic            motor_running_i,
   input  wire logic            alarm_event_i,
   input  wire logic [7:0]      alarm_code_i,
   input  wire logic [15:0]     shaft_speed_i,
   input  wire logic [NIN-1:0]  io_in_i,
   input  wire logic [NOUT-2:0] io_out_i,
   // Panel and system outputs
   output logic                 alarm_out_o,
   output logic [NIN+NOUT-1:0]  io_segments_o,
   output logic [1:0]           data_index_o,
   output logic [15:0]          mon_speed_o,
   output logic [7:0]           mon_alarm_code_o,
   output logic                 panel_error_o,
   output logic [15:0]          set_speed_o,
   output logic [7:0]           set_acc_o,
   output logic [7:0]           set_dec_o,
   output logic                 irq_o
);
   // ==========================================================
   // Synchronised pins
   localparam int NSY = 4 + 8 + 16 + NIN + NOUT - 1;
   logic [NSY-1:0] pin_raw;
   logic [NSY-1:0] pin_syn;
   logic           sel_lo, sel_hi, running, alarm_ev;
   logic [7:0]     acode;
   logic [15:0]    shaft;
   logic [NIN-1:0] in_s;
   logic [NOUT-2:0] out_s;

   // Pack order must match the unpack below
   assign pin_raw = {data_select_low_i, data_select_high_i, motor_running_i, alarm_event_i,
                     alarm_code_i, shaft_speed_i, io_in_i, io_out_i};
   assign {sel_lo, sel_hi, running, alarm_ev, acode, shaft, in_s, out_s} = pin_syn;

   // One shared synchroniser; multi-bit words must be held steady
   msd_sync #(.W(NSY)) u_sync (
      .mclk_i   (mclk_i),
      .sys_rst_i(sys_rst_i),
      .async_i  (pin_raw),
      .sync_o   (pin_syn)
   );

   // ==========================================================
   // State; history entry 0 is the newest alarm
   typedef logic [MSD_HIST_DEPTH-1:0] [7:0] msd_hist_t;
   typedef struct packed {
      msd_set_t [NSETS-1:0]                sets;
      msd_hist_t                           hist;
      logic [3:0]                          hist_cnt;
      logic [7:0]                          cur_alarm;
      logic                                alarm_act;
      logic                                alarm_ev_d;
      logic                                hz60;
      logic                                decel_en;
      logic                                ratio_en;
      logic [15:0]                         ratio;
      logic                                err;
      logic [3:0]                          irq_st;
      logic [3:0]                          irq_mk;
      logic [1:0]                          idx;
      logic [15:0]                         mon_spd;
      logic [31:0]                         rdat;
      logic                                ack;
   } msd_st_t;
   msd_st_t st_reg, st_next;

   // ==========================================================
   // Helper functions
   // Speed legal for the current mains and deceleration setting
   function automatic logic spd_ok(input logic [15:0] v, input logic hz60, input logic dec);
      logic [15:0] lo;
      logic [15:0] hi;
      lo = dec ? MSD_SPD_MIN_DEC : MSD_SPD_MIN;
      hi = hz60 ? MSD_SPD_MAX60 : MSD_SPD_MAX50;
      return (v == 16'h0000) || (v >= lo && v <= hi);
   endfunction : spd_ok

   // Time legal, in tenths of a second
   function automatic logic tim_ok(input logic [7:0] v, input logic zero_ok);
      return (v <= MSD_TIM_MAX) && (v >= (zero_ok ? MSD_TIM_MIN_DEC : MSD_TIM_MIN));
   endfunction : tim_ok

   // Default data set
   function automatic msd_set_t set_dflt(input logic dec);
      msd_set_t s;
      s.speed = MSD_SPD_RST;
      s.acc   = MSD_TIM_RST;
      s.dec   = dec ? MSD_TIM_RST_DEC : MSD_TIM_RST;
      return s;
   endfunction : set_dflt

   // Push a code at the newest end; the oldest entry drops off
   function automatic msd_hist_t hist_push(input msd_hist_t h, input logic [7:0] code);
      msd_hist_t r;
      r    = h << 8;
      r[0] = code;
      return r;
   endfunction : hist_push

   // Bus decode; the registered ack masks a strobe still held
   logic        wb_req;
   logic        wr;
   logic [1:0]  widx;
   logic [31:0] prod;
   assign wb_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
   // Writes need byte lane 0; other lanes alone are ignored
   assign wr     = wb_req && wb_we_i && wb_sel_i[0];
   assign widx   = wb_dat_i[17:16];
   assign prod   = shaft * st_reg.ratio;

   // ==========================================================
   // Next state: bus decode, data storage, alarms, monitor
   always_comb begin
      logic [3:0] ev;
      st_next     = st_reg;
      ev          = 4'h0;
      st_next.ack = wb_req;
      st_next.idx = {sel_hi, sel_lo};
      // Selection change event for software that tracks the panel
      if (st_reg.idx != {sel_hi, sel_lo}) begin
         ev[MSD_IRQ_SELCHG] = 1'b1;
      end
      // Converted speed; ratio held in hundredths
      st_next.mon_spd = st_reg.ratio_en ? 16'(prod / 32'd100) : shaft;
      // Alarm capture on the rising event, pushed into history
      st_next.alarm_ev_d = alarm_ev;
      if (alarm_ev && !st_reg.alarm_ev_d) begin
         st_next.alarm_act = 1'b1;
         st_next.cur_alarm = acode;
         st_next.hist      = hist_push(st_reg.hist, acode);
         if (st_reg.hist_cnt != 4'(MSD_HIST_DEPTH)) begin
            st_next.hist_cnt = st_reg.hist_cnt + 4'h1;
         end
         ev[MSD_IRQ_ALARM] = 1'b1;
      end
      // Register writes
      st_next.rdat = 32'h0000_0000;
      if (wr) begin
         unique case (wb_adr_i)
            MSD_OFF_CTRL: begin
               if (running) begin
                  st_next.err = 1'b1;
                  ev[MSD_IRQ_REFUSE] = 1'b1;
               end else begin
                  st_next.err      = 1'b0;
                  st_next.hz60     = wb_dat_i[MSD_CTRL_HZ60];
                  st_next.decel_en = wb_dat_i[MSD_CTRL_DECEL];
                  st_next.ratio_en = wb_dat_i[MSD_CTRL_RATIO];
                  if (wb_dat_i[MSD_CTRL_INIT]) begin
                     for (int i = 0; i < NSETS; i++) begin
                        st_next.sets[i] = set_dflt(wb_dat_i[MSD_CTRL_DECEL]);
                     end
                  end
                  // Alarm reset loses to an alarm input still high
                  if (wb_dat_i[MSD_CTRL_ARST] && !alarm_ev) begin
                     st_next.alarm_act = 1'b0;
                     st_next.cur_alarm = 8'h00;
                  end
                  // A clear keeps an alarm raised in the same cycle as the only entry
                  if (wb_dat_i[MSD_CTRL_HCLR]) begin
                     st_next.hist     = '0;
                     st_next.hist_cnt = 4'h0;
                     if (alarm_ev && !st_reg.alarm_ev_d) begin
                        st_next.hist     = hist_push('0, acode);
                        st_next.hist_cnt = 4'h1;
                     end
                  end
               end
            end
            MSD_OFF_IRQ_MK: st_next.irq_mk = wb_dat_i[3:0];
            MSD_OFF_RATIO: begin
               if (running) begin
                  st_next.err = 1'b1;
                  ev[MSD_IRQ_REFUSE] = 1'b1;
               end else begin
                  // A zero ratio shows zero speed; software must avoid it
                  st_next.ratio = wb_dat_i[15:0];
               end
            end
            // Limits use the stored mode bits, not this write's
            MSD_OFF_SPEED, MSD_OFF_ACC, MSD_OFF_DEC: begin
               if (running) begin
                  st_next.err = 1'b1;
                  ev[MSD_IRQ_REFUSE] = 1'b1;
               end else if (wb_adr_i == MSD_OFF_SPEED &&
                            spd_ok(wb_dat_i[15:0], st_reg.hz60, st_reg.decel_en)) begin
                  st_next.sets[widx].speed = wb_dat_i[15:0];
               end else if (wb_adr_i == MSD_OFF_ACC && tim_ok(wb_dat_i[7:0], 1'b0)) begin
                  st_next.sets[widx].acc = wb_dat_i[7:0];
               end else if (wb_adr_i == MSD_OFF_DEC &&
                            tim_ok(wb_dat_i[7:0], st_reg.decel_en)) begin
                  st_next.sets[widx].dec = wb_dat_i[7:0];
               end else begin
                  ev[MSD_IRQ_RANGE] = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Register reads
      if (wb_req && !wb_we_i) begin
         // History window of nine words above the fixed map
         if (wb_adr_i >= MSD_OFF_HIST0 &&
             wb_adr_i < MSD_OFF_HIST0 + 8'(4 * MSD_HIST_DEPTH)) begin
            st_next.rdat = {24'h0, st_reg.hist[4'((wb_adr_i - MSD_OFF_HIST0) >> 2)]};
         end else begin
            unique case (wb_adr_i)
               MSD_OFF_CTRL:   st_next.rdat = {26'h0, st_reg.ratio_en, 3'h0,
                                               st_reg.decel_en, st_reg.hz60};
               MSD_OFF_STATUS: st_next.rdat = {24'h0, st_reg.hist_cnt, running,
                                               st_reg.alarm_act, st_reg.err, 1'b0};
               MSD_OFF_IRQ_ST: st_next.rdat = {28'h0, st_reg.irq_st};
               MSD_OFF_IRQ_MK: st_next.rdat = {28'h0, st_reg.irq_mk};
               MSD_OFF_ALARM:  st_next.rdat = {24'h0, st_reg.cur_alarm};
               MSD_OFF_DSEL:   st_next.rdat = {30'h0, st_reg.idx};
               MSD_OFF_SPEED:  st_next.rdat = {16'h0, st_reg.sets[widx].speed};
               MSD_OFF_ACC:    st_next.rdat = {24'h0, st_reg.sets[widx].acc};
               MSD_OFF_DEC:    st_next.rdat = {24'h0, st_reg.sets[widx].dec};
               MSD_OFF_RATIO:  st_next.rdat = {16'h0, st_reg.ratio};
               MSD_OFF_MONSPD: st_next.rdat = {16'h0, st_reg.mon_spd};
               default:        st_next.rdat = 32'h0000_0000;
            endcase
         end
      end
      // Sticky status: read clears, but a new event in the same cycle wins
      if (wb_req && !wb_we_i && wb_adr_i == MSD_OFF_IRQ_ST) begin
         st_next.irq_st = ev;
      end else begin
         st_next.irq_st = st_reg.irq_st | ev;
      end
   end

   // Registers; reset loads the power-up defaults
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg          <= '0;
         for (int i = 0; i < NSETS; i++) begin
            st_reg.sets[i].acc <= MSD_TIM_RST;
            st_reg.sets[i].dec <= MSD_TIM_RST;
         end
         st_reg.ratio    <= MSD_RATIO_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   assign wb_ack_o         = st_reg.ack;
   assign wb_dat_o         = st_reg.rdat;
   assign alarm_out_o      = !st_reg.alarm_act;
   assign io_segments_o    = {alarm_out_o, out_s, in_s};
   assign data_index_o     = st_reg.idx;
   assign mon_speed_o      = st_reg.mon_spd;
   assign mon_alarm_code_o = st_reg.cur_alarm;
   assign panel_error_o    = st_reg.err;
   // Active set values follow the index with no extra delay
   assign set_speed_o      = st_reg.sets[st_reg.idx].speed;
   assign set_acc_o        = st_reg.sets[st_reg.idx].acc;
   assign set_dec_o        = st_reg.sets[st_reg.idx].dec;
   assign irq_o            = |(st_reg.irq_st & st_reg.irq_mk);
endmodule : msd_core
`default_nettype wire

// >>> verification/msd_core_assertions.sv
// Port checker for the speed data select monitor core
`timescale 1ns/10ps
`default_nettype none
module msd_core_assertions
   import msd_pkg::*;
#(
   parameter int NIN  = 6,
   parameter int NOUT = 2
) (
   // Clock, reset and bus
   input  wire logic                mclk_i,
   input  wire logic                sys_rst_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic                wb_ack_o,
   // Pins and panel outputs
   input  wire logic                data_select_low_i,
   input  wire logic                data_select_high_i,
   input  wire logic                alarm_event_i,
   input  wire logic [7:0]          alarm_code_i,
   input  wire logic [NIN-1:0]      io_in_i,
   input  wire logic                alarm_out_o,
   input  wire logic [NIN+NOUT-1:0] io_segments_o,
   input  wire logic [1:0]          data_index_o,
   input  wire logic [7:0]          mon_alarm_code_o,
   input  wire logic                panel_error_o,
   input  wire logic [15:0]         set_speed_o,
   input  wire logic [7:0]          set_acc_o,
   input  wire logic [7:0]          set_dec_o
);
   // ==========================================================
   // Single clock domain, so clock and disable are stated once
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_next_cycle: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");
   // Seven quiet samples cover the synchroniser plus the index register
   a_index_from_pins: assert property (
      $stable({data_select_high_i, data_select_low_i})[*7]
      |-> data_index_o == {data_select_high_i, data_select_low_i})
      else $error("data index does not follow select pins");
   a_segment_lit: assert property ($stable(io_in_i)[*7] |->
      io_segments_o[NIN-1:0] == io_in_i)
      else $error("input segments do not follow inputs");
   a_alarm_shown: assert property (
      ($rose(alarm_event_i) ##1 $stable({alarm_event_i, alarm_code_i})[*7])
      |-> (!alarm_out_o && mon_alarm_code_o == alarm_code_i))
      else $error("raised alarm not shown");
   a_speed_in_range: assert property (set_speed_o == 16'h0000 ||
      (set_speed_o >= MSD_SPD_MIN_DEC && set_speed_o <= MSD_SPD_MAX60))
      else $error("set speed out of range");
   a_time_in_range: assert property (set_acc_o >= MSD_TIM_MIN &&
      set_acc_o <= MSD_TIM_MAX && set_dec_o <= MSD_TIM_MAX)
      else $error("set time out of range");
   a_error_by_write: assert property ($rose(panel_error_o) |->
      $past(wb_cyc_i && wb_stb_i && wb_we_i))
      else $error("panel error without a write");
endmodule : msd_core_assertions
bind msd_core msd_core_assertions #(.NIN(NIN), .NOUT(NOUT)) chk_u (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .data_select_low_i(data_select_low_i),
   .data_select_high_i(data_select_high_i), .alarm_event_i(alarm_event_i),
   .alarm_code_i(alarm_code_i), .io_in_i(io_in_i), .alarm_out_o(alarm_out_o),
   .io_segments_o(io_segments_o), .data_index_o(data_index_o),
   .mon_alarm_code_o(mon_alarm_code_o), .panel_error_o(panel_error_o),
   .set_speed_o(set_speed_o), .set_acc_o(set_acc_o), .set_dec_o(set_dec_o));
`default_nettype wire

// >>> verification/msd_panel_model.sv
// Model of the operator panel and external control lines
`timescale 1ns/10ps
`default_nettype none
module msd_panel_model (
   // Clock
   input  wire logic   mclk_i,
   // Control lines, high means on
   output logic        sel_low_o,
   output logic        sel_high_o,
   output logic        run_o,
   output logic        alarm_o,
   output logic [7:0]  code_o,
   output logic [15:0] shaft_o,
   output logic [5:0]  io_in_o,
   output logic [0:0]  io_out_o
);
   // ==========================================================
   // Idle panel: motor stopped, no alarm, shaft at a fixed rate
   initial begin
      {sel_high_o, sel_low_o, run_o, alarm_o} = 4'h0;
      code_o   = 8'h00;
      shaft_o  = 16'd1000;
      io_in_o  = 6'h00;
      io_out_o = 1'b0;
   end
   // Both selects move on one edge so no stray index is seen
   task automatic sel(input logic [1:0] s);
      @(posedge mclk_i);
      {sel_high_o, sel_low_o} <= s;
   endtask : sel
   task automatic run(input logic r);
      @(posedge mclk_i);
      run_o <= r;
   endtask : run
   task automatic io(input logic [5:0] i, input logic o);
      @(posedge mclk_i);
      io_in_o  <= i;
      io_out_o <= o;
   endtask : io
   // Code is held steady over the whole pulse, as the core samples it late
   task automatic alarm(input logic [7:0] c);
      @(posedge mclk_i);
      alarm_o <= 1'b1;
      code_o  <= c;
      repeat (10) @(posedge mclk_i);
      alarm_o <= 1'b0;
      repeat (10) @(posedge mclk_i);
   endtask : alarm
endmodule : msd_panel_model
`default_nettype wire

// >>> verification/msd_core_tb_top.sv
// Self-checking bench for the speed data select monitor core
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin fails++; \
   $display("FAIL %s exp %0h got %0h", n, e, v); end end
module msd_core_tb_top;
   import msd_pkg::*;
   // ==========================================================
   // Signals
   logic        mclk_i = 1'b0, sys_rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, q, rdat;
   logic        ack, sl, sh, run, aev, aout, perr, irq;
   logic [7:0]  acode, mcode, sacc, sdec, seg;
   logic [15:0] shaft, mspd, sspd;
   logic [5:0]  ioin;
   logic [0:0]  ioout;
   logic [1:0]  idx;
   int          fails = 0, checks = 0;
   initial forever #50 mclk_i = ~mclk_i;
   msd_panel_model pm_u (.mclk_i(mclk_i), .sel_low_o(sl), .sel_high_o(sh), .run_o(run),
      .alarm_o(aev), .code_o(acode), .shaft_o(shaft), .io_in_o(ioin), .io_out_o(ioout));
   msd_core dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .data_select_low_i(sl), .data_select_high_i(sh),
      .motor_running_i(run), .alarm_event_i(aev), .alarm_code_i(acode),
      .shaft_speed_i(shaft), .io_in_i(ioin), .io_out_i(ioout), .alarm_out_o(aout),
      .io_segments_o(seg), .data_index_o(idx), .mon_speed_o(mspd),
      .mon_alarm_code_o(mcode), .panel_error_o(perr), .set_speed_o(sspd),
      .set_acc_o(sacc), .set_dec_o(sdec), .irq_o(irq));
   // ==========================================================
   // Classic single cycle; ends one idle edge after the ack edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      logic hit;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      // Ack and read data are looked at mid-cycle, where they stand settled
      do begin
         @(negedge mclk_i);
         hit = (ack === 1'b1);
         q   = rdat;
         @(posedge mclk_i);
         n++;
      end while (!hit && n < 40);
      if (!hit) fails++;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge mclk_i);
   endtask : wb
   task automatic rc(string nm, input logic [7:0] a, input logic [31:0] d, e);
      wb(1'b0, a, d);
      `CHK(nm, e, q)
   endtask : rc
   // Write set one, then read the stored field back
   task automatic tw(input logic [7:0] a, input logic [15:0] v, e);
      wb(1'b1, a, {16'h0001, v});
      rc("field", a, 32'h10000, {16'h0, e});
   endtask : tw
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   // Watchdog well beyond the several hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge mclk_i);
      fails++;
      stop_test;
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      `CHK("alarm_out", 1'b1, aout)
      for (int s = 0; s < 4; s++) begin
         rc("spd_rst", MSD_OFF_SPEED, s << 16, 32'h0);
         rc("acc_rst", MSD_OFF_ACC, s << 16, 32'h2);
         rc("dec_rst", MSD_OFF_DEC, s << 16, 32'h2);
         wb(1'b1, MSD_OFF_SPEED, (s << 16) | (300 + 100 * s));
      end
      rc("ratio_rst", MSD_OFF_RATIO, 32'h0, 32'd100);
      wb(1'b1, 8'hfc, 32'hffff);
      rc("unmapped", 8'hfc, 32'h0, 32'h0);
      for (int s = 0; s < 4; s++) begin
         pm_u.sel(s[1:0]);
         repeat (8) @(posedge mclk_i);
         `CHK("index", s[1:0], idx)
         `CHK("set_speed", 16'(300 + 100 * s), sspd)
         rc("dsel", MSD_OFF_DSEL, 32'h0, s);
      end
      // Only range refusals reach the interrupt line
      wb(1'b1, MSD_OFF_IRQ_MK, 32'h4);
      wb(1'b0, MSD_OFF_IRQ_ST, 32'h0);
      `CHK("irq_idle", 1'b0, irq)
      tw(MSD_OFF_SPEED, 16'd299, 16'd400);
      `CHK("irq_set", 1'b1, irq)
      rc("irq_st", MSD_OFF_IRQ_ST, 32'h0, 32'h4);
      `CHK("irq_clr", 1'b0, irq)
      tw(MSD_OFF_SPEED, 16'd1400, 16'd1400);
      tw(MSD_OFF_SPEED, 16'd1401, 16'd1400);
      wb(1'b1, MSD_OFF_CTRL, 32'h1);
      tw(MSD_OFF_SPEED, 16'd1600, 16'd1600);
      tw(MSD_OFF_SPEED, 16'd1601, 16'd1600);
      tw(MSD_OFF_SPEED, 16'd90, 16'd1600);
      wb(1'b1, MSD_OFF_CTRL, 32'h3);
      tw(MSD_OFF_SPEED, 16'd90, 16'd90);
      tw(MSD_OFF_SPEED, 16'd89, 16'd90);
      tw(MSD_OFF_DEC, 16'd0, 16'd0);
      tw(MSD_OFF_DEC, 16'd151, 16'd0);
      tw(MSD_OFF_ACC, 16'd0, 16'd2);
      tw(MSD_OFF_ACC, 16'd150, 16'd150);
      tw(MSD_OFF_ACC, 16'd151, 16'd150);
      wb(1'b1, MSD_OFF_CTRL, 32'h4);
      rc("init_spd", MSD_OFF_SPEED, 32'h10000, 32'h0);
      rc("init_acc", MSD_OFF_ACC, 32'h10000, 32'h2);
      rc("init_dec", MSD_OFF_DEC, 32'h10000, 32'h2);
      rc("init_set3", MSD_OFF_SPEED, 32'h30000, 32'h0);
      `CHK("set_times", 16'h0202, {sacc, sdec})
      wb(1'b1, MSD_OFF_CTRL, 32'h6);
      rc("init_dec0", MSD_OFF_DEC, 32'h20000, 32'h0);
      pm_u.run(1'b1);
      repeat (8) @(posedge mclk_i);
      wb(1'b1, MSD_OFF_SPEED, 32'h101f4);
      `CHK("panel_err", 1'b1, perr)
      rc("run_spd", MSD_OFF_SPEED, 32'h10000, 32'h0);
      rc("irq_refuse", MSD_OFF_IRQ_ST, 32'h0, 32'h6);
      pm_u.run(1'b0);
      repeat (8) @(posedge mclk_i);
      wb(1'b1, MSD_OFF_RATIO, 32'd200);
      wb(1'b1, MSD_OFF_CTRL, 32'h20);
      `CHK("err_clr", 1'b0, perr)
      repeat (4) @(posedge mclk_i);
      `CHK("mon_ratio", 16'd2000, mspd)
      rc("mon_reg", MSD_OFF_MONSPD, 32'h0, 32'd2000);
      wb(1'b1, MSD_OFF_CTRL, 32'h0);
      repeat (4) @(posedge mclk_i);
      `CHK("mon_raw", 16'd1000, mspd)
      pm_u.io(6'h2d, 1'b1);
      repeat (8) @(posedge mclk_i);
      `CHK("segments", 7'h6d, seg[6:0])
      for (int i = 0; i < 10; i++) pm_u.alarm(8'h10 + 8'(i));
      `CHK("alarm_off", 1'b0, aout)
      `CHK("alarm_seg", 1'b0, seg[7])
      `CHK("alarm_code", 8'h19, mcode)
      rc("hist_new", MSD_OFF_HIST0, 32'h0, 32'h19);
      rc("hist_old", MSD_OFF_HIST0 + 8'h20, 32'h0, 32'h11);
      wb(1'b0, MSD_OFF_STATUS, 32'h0);
      `CHK("hist_cnt", 4'd9, q[7:4])
      wb(1'b1, MSD_OFF_CTRL, 32'h8);
      repeat (2) @(posedge mclk_i);
      `CHK("alarm_rst", 1'b1, aout)
      `CHK("code_rst", 8'h00, mcode)
      wb(1'b1, MSD_OFF_CTRL, 32'h10);
      wb(1'b0, MSD_OFF_STATUS, 32'h0);
      `CHK("hist_clr", 4'd0, q[7:4])
      stop_test;
   end
endmodule : msd_core_tb_top
`default_nettype wire
